// ### core/rosc_regs.svh
// Constants of the radio operating state controller.
`ifndef ROSC_REGS_SVH
`define ROSC_REGS_SVH

`define ROSC_CMD_W          3
`define ROSC_CMD_NOP        3'h0
`define ROSC_CMD_READY      3'h1
`define ROSC_CMD_LOCK       3'h2
`define ROSC_CMD_TX         3'h3
`define ROSC_CMD_RX         3'h4
`define ROSC_CMD_SLEEP      3'h5
`define ROSC_CMD_STANDBY    3'h6

`define ROSC_GPIO_N         4
`define ROSC_CFG_N          4
`define ROSC_CFG_AW         2
`define ROSC_CFG_DW         8
`define ROSC_CFG_RESET      8'h00

`define ROSC_CLK_PERIOD_NS  8
`define ROSC_LOCK_SETTLE_NS 64
`define ROSC_LOCK_SETTLE_CYC \
  ((`ROSC_LOCK_SETTLE_NS + `ROSC_CLK_PERIOD_NS - 1) / `ROSC_CLK_PERIOD_NS)
`define ROSC_CNT_W          4

`endif

// ### core/rosc_pkg.sv
// Types of the radio operating state controller.
package rosc_pkg;

  typedef enum logic [2:0] {
    ST_SHUTDOWN,
    ST_READY,
    ST_LOCK,
    ST_TX,
    ST_RX,
    ST_SLEEP,
    ST_STANDBY
  } rosc_state_type;

  typedef struct packed {
    logic go_ready;
    logic go_lock;
    logic go_tx;
    logic go_rx;
    logic go_sleep;
    logic go_standby;
  } rosc_req_type;

endpackage

// ### core/rosc_req_if.sv
// Decoded transition requests passed from the command decoder to the controller.
`timescale 1ns/100ps
interface rosc_req_if;
  import rosc_pkg::*;
  rosc_req_type req;
  modport dec (output req);
  modport ctl (input req);
endinterface

// ### core/rosc_cmd.sv
// Serial command decoder that turns a command code into one registered request pulse.
`timescale 1ns/100ps
`include "rosc_regs.svh"
module rosc_cmd (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic                   power_down_pin,
  input  wire logic                   cmd_valid,
  input  wire logic [`ROSC_CMD_W-1:0] cmd_code,
  rosc_req_if.dec                     req_bus
);
  import rosc_pkg::*;

  typedef struct packed {
    rosc_req_type req;
  } rosc_cmd_st_type;

  rosc_cmd_st_type st_q;
  rosc_cmd_st_type st_d;

  function automatic rosc_req_type decode(input logic [`ROSC_CMD_W-1:0] code);
    rosc_req_type r;
    r = '0;
    r.go_ready   = (code == `ROSC_CMD_READY);
    r.go_lock    = (code == `ROSC_CMD_LOCK);
    r.go_tx      = (code == `ROSC_CMD_TX);
    r.go_rx      = (code == `ROSC_CMD_RX);
    r.go_sleep   = (code == `ROSC_CMD_SLEEP);
    r.go_standby = (code == `ROSC_CMD_STANDBY);
    return r;
  endfunction

  // Commands are accepted only over the serial port and only while powered.
  always_comb begin
    st_d = '0;
    if (cmd_valid && !power_down_pin) begin
      st_d.req = decode(cmd_code);
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign req_bus.req = st_q.req;

endmodule

// ### core/rosc_top.sv
// Operating state controller of a sub-1 GHz radio transceiver.
//
// Operation
// - Power on and off is done only by the dedicated power-down pin, all else goes by commands.
// - In shutdown every stored datum and setting is cleared, so power-up starts from defaults.
// - In shutdown all general-purpose and serial output enables are low, leaving pins floating.
// - Releasing the power-down pin brings the device to ready with the crystal reference on.
// - From ready the device may go to lock, which makes the local oscillator, then to TX or RX.
// - The device never passes directly between receive and transmit, always through lock.
// - One TX or RX command runs the whole sequence, including the lock step, by itself.
// - TX, RX and lock may return to ready, and ready may enter sleep.
// - Ready may enter standby, the lowest-current state short of shutdown.
// - Standby keeps buffer, status and configuration contents intact.
// - All transitions other than shutdown are made by this state machine on serial commands.
// - The power-down pin is active high: high holds shutdown, low lets the device run.
`timescale 1ns/100ps
`include "rosc_regs.svh"
module rosc_top (
  input  wire logic                    mclk,
  input  wire logic                    rst,
  input  wire logic                    power_down_pin,
  input  wire logic                    cmd_valid,
  input  wire logic [`ROSC_CMD_W-1:0]  cmd_code,
  input  wire logic                    cfg_we,
  input  wire logic [`ROSC_CFG_AW-1:0] cfg_addr,
  input  wire logic [`ROSC_CFG_DW-1:0] cfg_wdata,
  output rosc_pkg::rosc_state_type     op_state,
  output logic                         crystal_reference,
  output logic                         local_oscillator_signal,
  output logic [`ROSC_GPIO_N-1:0]      gpio_oe,
  output logic                         spi_miso_oe,
  output logic [`ROSC_CFG_DW-1:0]      cfg_rdata
);
  import rosc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    rosc_state_type                                state;
    logic                                          pend_tx;
    logic                                          pend_rx;
    logic [`ROSC_CNT_W-1:0]                        cnt;
    logic                                          xo;
    logic                                          lo;
    logic [`ROSC_GPIO_N-1:0]                       gpio_oe;
    logic                                          miso_oe;
    logic [`ROSC_CFG_N-1:0][`ROSC_CFG_DW-1:0]      cfg;
    logic [`ROSC_CFG_DW-1:0]                       rdata;
  } rosc_top_st_type;

  localparam logic [`ROSC_CNT_W-1:0] SETTLE = `ROSC_CNT_W'(`ROSC_LOCK_SETTLE_CYC);

  rosc_top_st_type st_q;
  rosc_top_st_type st_d;
  rosc_req_type    rq;

  rosc_req_if req_bus ();

  rosc_cmd u_cmd (
    .mclk           (mclk),
    .rst            (rst),
    .power_down_pin (power_down_pin),
    .cmd_valid      (cmd_valid),
    .cmd_code       (cmd_code),
    .req_bus        (req_bus.dec)
  );

  assign rq = req_bus.req;

  function automatic logic is_active(input rosc_state_type s);
    return (s == ST_READY) || (s == ST_LOCK) || (s == ST_TX) || (s == ST_RX);
  endfunction

  function automatic logic has_lo(input rosc_state_type s);
    return (s == ST_LOCK) || (s == ST_TX) || (s == ST_RX);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    logic pt;
    logic pr;
    pt   = st_q.pend_tx;
    pr   = st_q.pend_rx;
    st_d = st_q;
    st_d.rdata = st_q.cfg[cfg_addr];
    // Contents are written only in active states, so standby and sleep keep them.
    if (cfg_we && is_active(st_q.state)) begin
      st_d.cfg[cfg_addr] = cfg_wdata;
    end
    if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - `ROSC_CNT_W'(1);
    end
    unique case (st_q.state)
      ST_SHUTDOWN: begin
        st_d.state = ST_READY;
      end
      ST_READY: begin
        if (rq.go_lock || rq.go_tx || rq.go_rx) begin
          st_d.state   = ST_LOCK;
          st_d.cnt     = SETTLE;
          st_d.pend_tx = rq.go_tx;
          st_d.pend_rx = rq.go_rx;
        end else if (rq.go_sleep) begin
          st_d.state = ST_SLEEP;
        end else if (rq.go_standby) begin
          st_d.state = ST_STANDBY;
        end
      end
      ST_LOCK: begin
        if (rq.go_tx) begin
          pt = 1'b1;
          pr = 1'b0;
        end else if (rq.go_rx) begin
          pt = 1'b0;
          pr = 1'b1;
        end
        st_d.pend_tx = pt;
        st_d.pend_rx = pr;
        if (rq.go_ready) begin
          st_d.state   = ST_READY;
          st_d.pend_tx = 1'b0;
          st_d.pend_rx = 1'b0;
        end else if (st_q.cnt == '0 && pt) begin
          st_d.state   = ST_TX;
          st_d.pend_tx = 1'b0;
        end else if (st_q.cnt == '0 && pr) begin
          st_d.state   = ST_RX;
          st_d.pend_rx = 1'b0;
        end
      end
      ST_TX, ST_RX: begin
        if (rq.go_ready) begin
          st_d.state = ST_READY;
        end else if (rq.go_lock || (rq.go_rx && st_q.state == ST_TX) ||
                     (rq.go_tx && st_q.state == ST_RX)) begin
          st_d.state   = ST_LOCK;
          st_d.cnt     = SETTLE;
          st_d.pend_tx = rq.go_tx;
          st_d.pend_rx = rq.go_rx;
        end
      end
      ST_SLEEP, ST_STANDBY: begin
        if (rq.go_ready) begin
          st_d.state = ST_READY;
        end
      end
      default: begin
        st_d.state = ST_READY;
      end
    endcase
    st_d.xo      = (st_d.state != ST_SHUTDOWN);
    st_d.lo      = has_lo(st_d.state);
    st_d.gpio_oe = {`ROSC_GPIO_N{st_d.state != ST_SHUTDOWN}};
    st_d.miso_oe = (st_d.state != ST_SHUTDOWN);
    // A high power-down pin overrides everything and wipes all contents.
    if (power_down_pin) begin
      st_d = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign op_state                = st_q.state;
  assign crystal_reference       = st_q.xo;
  assign local_oscillator_signal = st_q.lo;
  assign gpio_oe                 = st_q.gpio_oe;
  assign spi_miso_oe             = st_q.miso_oe;
  assign cfg_rdata               = st_q.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  a_pin_forces_down: assert property (@(posedge mclk) disable iff (rst)
    power_down_pin |=> (st_q.state == ST_SHUTDOWN) && !crystal_reference)
    else $error("power-down pin did not force shutdown");

  a_shutdown_hiz: assert property (@(posedge mclk) disable iff (rst)
    (st_q.state == ST_SHUTDOWN) |-> (gpio_oe == '0) && !spi_miso_oe)
    else $error("outputs enabled during shutdown");

  a_shutdown_clears: assert property (@(posedge mclk) disable iff (rst)
    $past(power_down_pin) |-> (st_q.cfg == '0) && (cfg_rdata == '0))
    else $error("contents survived shutdown");

  a_wake_ready: assert property (@(posedge mclk) disable iff (rst)
    !rst && (st_q.state == ST_SHUTDOWN) && !power_down_pin
    |=> (st_q.state == ST_READY) && crystal_reference && spi_miso_oe)
    else $error("release did not reach ready");

  a_no_direct_swap: assert property (@(posedge mclk) disable iff (rst)
    ((st_q.state == ST_TX) |=> (st_q.state != ST_RX)) and
    ((st_q.state == ST_RX) |=> (st_q.state != ST_TX)))
    else $error("direct switch between receive and transmit");

  a_radio_via_lock: assert property (@(posedge mclk) disable iff (rst)
    $rose(local_oscillator_signal) |-> (st_q.state == ST_LOCK) && ($past(st_q.state) == ST_READY))
    else $error("oscillator started outside lock");

  a_auto_sequence: assert property (@(posedge mclk) disable iff (rst)
    (st_q.state == ST_READY) && rq.go_tx && !power_down_pin ##1
    (!power_down_pin && rq == '0) [*8] ##1 (!power_down_pin && rq == '0)
    |=> (st_q.state == ST_TX))
    else $error("single command did not reach transmit");

  a_back_to_ready: assert property (@(posedge mclk) disable iff (rst)
    has_lo(st_q.state) && rq.go_ready && !power_down_pin |=> (st_q.state == ST_READY))
    else $error("ready command not obeyed");

  a_standby_entry: assert property (@(posedge mclk) disable iff (rst)
    (st_q.state == ST_READY) && rq == 6'h01 && !power_down_pin |=> (st_q.state == ST_STANDBY))
    else $error("standby not entered from ready");

  a_standby_keeps: assert property (@(posedge mclk) disable iff (rst)
    (st_q.state == ST_STANDBY) && !power_down_pin |=> $stable(st_q.cfg))
    else $error("standby lost contents");

  a_only_commands: assert property (@(posedge mclk) disable iff (rst)
    is_active(st_q.state) && rq == '0 && !st_q.pend_tx && !st_q.pend_rx && !power_down_pin
    |=> $stable(st_q.state))
    else $error("state moved without a command");

  a_illegal_ignored: assert property (@(posedge mclk) disable iff (rst)
    (st_q.state == ST_SLEEP) && !rq.go_ready && !power_down_pin |=> (st_q.state == ST_SLEEP))
    else $error("illegal command changed sleep state");

endmodule

// ### dv/rosc_host.sv
// Host model that drives commands and the power-down pin.
`timescale 1ns/100ps
`include "rosc_regs.svh"
module rosc_host (
  input  wire logic                   mclk,
  output logic                        power_down_pin,
  output logic                        cmd_valid,
  output logic [`ROSC_CMD_W-1:0]      cmd_code
);
  initial begin
    power_down_pin = 1'b0;
    cmd_valid      = 1'b0;
    cmd_code       = 3'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One strobe carries one command, and the code is scrambled once it drops.
  task automatic send(input logic [`ROSC_CMD_W-1:0] code);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_code  <= ~code;
  endtask
  // A high level holds shutdown and a low level lets the device run.
  task automatic set_pdn(input logic lvl);
    @(posedge mclk);
    power_down_pin <= lvl;
  endtask
endmodule

// ### dv/rosc_top_tb.sv
// Self-checking testbench of the radio operating state controller.
`timescale 1ns/100ps
`include "rosc_regs.svh"
module rosc_top_tb;
  import rosc_pkg::*;
  logic                   mclk;
  logic                   rst;
  logic                   power_down_pin;
  logic                   cmd_valid;
  logic [2:0]             cmd_code;
  logic                   cfg_we;
  logic [1:0]             cfg_addr;
  logic [7:0]             cfg_wdata;
  rosc_state_type         op_state;
  logic                   crystal_reference;
  logic                   local_oscillator_signal;
  logic [3:0]             gpio_oe;
  logic                   spi_miso_oe;
  logic [7:0]             cfg_rdata;
  rosc_state_type         exp_q[$];
  rosc_state_type         prev;
  rosc_state_type         e;
  logic [7:0]             mem [4];
  int                     n;
  int                     num_errors = 0;
  int                     n_checks = 0;

  initial mclk = 1'b0;
  always #4 mclk = ~mclk;

  rosc_host u_host (.mclk(mclk), .power_down_pin(power_down_pin), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code));
  rosc_top u_dut (.mclk(mclk), .rst(rst), .power_down_pin(power_down_pin),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .op_state(op_state), .crystal_reference(crystal_reference),
    .local_oscillator_signal(local_oscillator_signal), .gpio_oe(gpio_oe),
    .spi_miso_oe(spi_miso_oe), .cfg_rdata(cfg_rdata));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Pin levels that belong to a state.
  function automatic logic [7:0] pins(input rosc_state_type s);
    logic on;
    on = (s != ST_SHUTDOWN);
    return {on, s inside {ST_LOCK, ST_TX, ST_RX}, on, 1'b0, {4{on}}};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Every change of state must match the oldest expected state.
  always @(negedge mclk) begin
    if (!rst && op_state !== prev) begin
      e = (exp_q.size() == 0) ? prev : exp_q.pop_front();
      check(8'(op_state), 8'(e));
      check({crystal_reference, local_oscillator_signal, spi_miso_oe, 1'b0, gpio_oe},
        pins(e));
    end
    prev = op_state;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wait_st(input rosc_state_type s);
    n = 0;
    while (op_state !== s && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (op_state !== s) begin
      num_errors++;
      tally_and_finish();
    end
  endtask
  task automatic go(input logic [2:0] code, input rosc_state_type s);
    exp_q.push_back(s);
    u_host.send(code);
    wait_st(s);
  endtask
  task automatic ignore(input logic [2:0] code, input rosc_state_type s);
    u_host.send(code);
    repeat (12) @(negedge mclk);
    check(8'(op_state), 8'(s));
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge mclk);
    cfg_we    <= 1'b1;
    cfg_addr  <= a;
    cfg_wdata <= d;
    @(posedge mclk);
    cfg_we    <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge mclk);
    cfg_addr <= a;
    @(posedge mclk);
    @(negedge mclk);
    check(cfg_rdata, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst       = 1'b1;
    cfg_we    = 1'b0;
    cfg_addr  = 2'h0;
    cfg_wdata = 8'h00;
    prev      = ST_SHUTDOWN;
    void'($urandom(20));
    repeat (10) @(posedge mclk);
    exp_q.push_back(ST_READY);
    rst <= 1'b0;
    wait_st(ST_READY);
    for (int i = 0; i < 4; i++) begin
      mem[i] = 8'($urandom());
      wr(2'(i), mem[i]);
    end
    for (int i = 0; i < 4; i++) rd(2'(i), mem[i]);
    ignore(`ROSC_CMD_NOP, ST_READY);
    ignore(3'h7, ST_READY);
    go(`ROSC_CMD_SLEEP, ST_SLEEP);
    ignore(`ROSC_CMD_TX, ST_SLEEP);
    ignore(`ROSC_CMD_LOCK, ST_SLEEP);
    ignore(`ROSC_CMD_STANDBY, ST_SLEEP);
    go(`ROSC_CMD_READY, ST_READY);
    exp_q.push_back(ST_LOCK);
    go(`ROSC_CMD_TX, ST_TX);
    check(8'(n), 8'(`ROSC_LOCK_SETTLE_CYC + 3));
    exp_q.push_back(ST_LOCK);
    go(`ROSC_CMD_RX, ST_RX);
    check(8'(n), 8'(`ROSC_LOCK_SETTLE_CYC + 3));
    go(`ROSC_CMD_LOCK, ST_LOCK);
    go(`ROSC_CMD_READY, ST_READY);
    go(`ROSC_CMD_LOCK, ST_LOCK);
    go(`ROSC_CMD_READY, ST_READY);
    go(`ROSC_CMD_STANDBY, ST_STANDBY);
    ignore(`ROSC_CMD_RX, ST_STANDBY);
    wr(2'h2, ~mem[2]);
    go(`ROSC_CMD_READY, ST_READY);
    for (int i = 0; i < 4; i++) rd(2'(i), mem[i]);
    exp_q.push_back(ST_SHUTDOWN);
    u_host.set_pdn(1'b1);
    wait_st(ST_SHUTDOWN);
    ignore(`ROSC_CMD_TX, ST_SHUTDOWN);
    exp_q.push_back(ST_READY);
    u_host.set_pdn(1'b0);
    wait_st(ST_READY);
    for (int i = 0; i < 4; i++) rd(2'(i), 8'h00);
    check(8'(exp_q.size()), 8'h00);
    tally_and_finish();
  end
endmodule
